// ---- verilog/ipic_ctrl.sv ----
// interrupt controller: pin sensing, priorities, break monitor and core handshake
// Function
// - 8-bit sense register for four pins
// - sense codes: low, fall, rise, both edges
// - pin3 at 7:6 down to pin0 1:0
// - upper sense byte reads zero
// - each source gets its own vector
// - software priority 0..15 per pin and peripheral source
// - acceptance loads source priority as mask
// - break request fixed at level 15
// - break request edge latched until accepted
// - break acceptance loads mask level 15
// - vector address is four times number
// - equal levels resolved by fixed order
// - any selection group 00 blocks break
// - match flags sticky, software writes zero
// - both channels flag, one request raised
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "ipic_cfg.svh"
module ipic_ctrl (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // register bus write
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // register bus read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // interrupt sources
    input wire logic [3:0] ext_int_pin,
    input wire logic nmi_pin,
    input wire logic [3:0] periph_req,
    input wire logic brk_cond_a,
    input wire logic brk_cond_b,
    // processor core
    input wire logic [3:0] cpu_mask_level,
    input wire logic cpu_ack,
    output logic int_req,
    output ipic_pkg::ipic_vector_t int_vector,
    output logic [9:0] int_table_addr,
    output logic [3:0] int_level,
    output logic irq_out
);
    import ipic_pkg::*;

    localparam int NSRC = 10;

    // registers
    logic [7:0] sense_reg;
    logic [15:0] prio_a_reg;
    logic [15:0] prio_cf_reg;
    logic [5:0] bsel_a_reg;
    logic [5:0] bsel_b_reg;
    logic [3:0] flags_reg;
    logic [2:0] status_reg;
    logic [2:0] mask_reg;
    logic brk_pend_reg;
    logic cond_a_reg;
    logic cond_b_reg;
    logic int_req_reg;
    ipic_vector_t int_vector_reg;
    logic [3:0] int_idx_reg;
    logic [3:0] int_level_reg;
    logic irq_out_reg;
    logic awready_reg;
    logic wready_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic arready_reg;
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;
    logic rd_sense_reg;

    // ---------------------------------------------
    // register bus decode
    // ---------------------------------------------
    logic wr_fire;
    logic rd_fire;
    logic wsel_sense;
    logic wsel_prio_a;
    logic wsel_prio_cf;
    logic wsel_bsel_a;
    logic wsel_bsel_b;
    logic wsel_bctrl;
    logic wsel_stat;
    logic wsel_mask;
    logic wr_hit;
    logic rd_hit;
    logic [31:0] rd_data_w;
    logic [15:0] wmask16;

    assign wr_fire = awready_reg && s_axi_awvalid && s_axi_wvalid;
    assign rd_fire = arready_reg && s_axi_arvalid;
    assign wsel_sense = wr_fire && s_axi_awaddr == `IPIC_OFF_SENSE;
    assign wsel_prio_a = wr_fire && s_axi_awaddr == `IPIC_OFF_PRIO_A;
    assign wsel_prio_cf = wr_fire && s_axi_awaddr == `IPIC_OFF_PRIO_CF;
    assign wsel_bsel_a = wr_fire && s_axi_awaddr == `IPIC_OFF_BSEL_A;
    assign wsel_bsel_b = wr_fire && s_axi_awaddr == `IPIC_OFF_BSEL_B;
    assign wsel_bctrl = wr_fire && s_axi_awaddr == `IPIC_OFF_BCTRL;
    assign wsel_stat = wr_fire && s_axi_awaddr == `IPIC_OFF_STAT;
    assign wsel_mask = wr_fire && s_axi_awaddr == `IPIC_OFF_MASK;
    assign wr_hit = wsel_sense || wsel_prio_a || wsel_prio_cf || wsel_bsel_a || wsel_bsel_b
        || wsel_bctrl || wsel_stat || wsel_mask;
    assign wmask16 = {{8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};

    // ---------------------------------------------
    // source collection and arbitration
    // ---------------------------------------------
    logic [3:0] pin_pend;
    logic nmi_pend;
    logic [NSRC-1:0] src_req;
    ipic_level_t src_lvl [NSRC];
    ipic_vector_t src_vec [NSRC];
    logic [NSRC-1:0] src_acc;
    logic ack_hit;
    logic best_hit;
    logic [3:0] best_idx;
    ipic_level_t best_lvl;

    assign ack_hit = cpu_ack && int_req_reg;
    assign src_req = {periph_req, pin_pend, nmi_pend, brk_pend_reg};
    assign src_lvl[0] = `IPIC_LVL_BRK;
    assign src_vec[0] = `IPIC_VEC_BRK;
    assign src_lvl[1] = `IPIC_LVL_NMI;
    assign src_vec[1] = `IPIC_VEC_NMI;

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_src
            ipic_sense_t mode_w;
            assign mode_w = ipic_sense_t'(sense_reg[`IPIC_SENSE_FW*g +: `IPIC_SENSE_FW]);
            ipic_pin_sense u_pin (
                .aclk(aclk),
                .aresetn(aresetn),
                .pin_async(ext_int_pin[g]),
                .mode(mode_w),
                .accept(src_acc[2+g]),
                .pending(pin_pend[g])
            );
            // pin0 owns the top priority nibble, pin3 the bottom one
            assign src_lvl[2+g] = {1'b0, prio_a_reg[`IPIC_PRIO_FW*(3-g) +: `IPIC_PRIO_FW]};
            assign src_vec[2+g] = `IPIC_VEC_PIN0 + 8'(g);
            assign src_lvl[6+g] = {1'b0, prio_cf_reg[`IPIC_PRIO_FW*(3-g) +: `IPIC_PRIO_FW]};
            assign src_vec[6+g] = `IPIC_VEC_PER0 + 8'(g * 4);
        end
    endgenerate

    ipic_pin_sense u_nmi (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin_async(nmi_pin),
        .mode(SENSE_FALL),
        .accept(src_acc[1]),
        .pending(nmi_pend)
    );

    always_comb begin
        best_hit = 1'b0;
        best_idx = 4'h0;
        best_lvl = 5'h00;
        src_acc = '0;
        // walk upward from the lowest ranked entry so ties go to the earlier one
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (src_req[i] && src_lvl[i] > {1'b0, cpu_mask_level} && (!best_hit || src_lvl[i] >= best_lvl)) begin
                best_hit = 1'b1;
                best_idx = 4'(i);
                best_lvl = src_lvl[i];
            end
            src_acc[i] = ack_hit && int_idx_reg == 4'(i);
        end
    end

    // ---------------------------------------------
    // break monitor
    // ---------------------------------------------
    logic cfg_ok_a;
    logic cfg_ok_b;
    logic match_a;
    logic match_b;
    logic [3:0] flag_set;
    logic [3:0] flag_keep;
    logic brk_pend_next;

    assign cfg_ok_a = bsel_a_reg[5:4] != 2'h0 && bsel_a_reg[3:2] != 2'h0 && bsel_a_reg[1:0] != 2'h0;
    assign cfg_ok_b = bsel_b_reg[5:4] != 2'h0 && bsel_b_reg[3:2] != 2'h0 && bsel_b_reg[1:0] != 2'h0;
    assign match_a = brk_cond_a && !cond_a_reg && cfg_ok_a;
    assign match_b = brk_cond_b && !cond_b_reg && cfg_ok_b;
    assign flag_set[`IPIC_FLAG_LBUS_A] = match_a && bsel_a_reg[4];
    assign flag_set[`IPIC_FLAG_IBUS_A] = match_a && bsel_a_reg[5];
    assign flag_set[`IPIC_FLAG_LBUS_B] = match_b && bsel_b_reg[4];
    assign flag_set[`IPIC_FLAG_IBUS_B] = match_b && bsel_b_reg[5];
    // flags only fall when software writes a zero; a new match wins
    assign flag_keep = (wsel_bctrl && s_axi_wstrb[0]) ? s_axi_wdata[3:0] : 4'hF;
    // both channels feed one latched request
    assign brk_pend_next = match_a || match_b || (brk_pend_reg && !src_acc[0]);

    // ---------------------------------------------
    // interrupt status and read data
    // ---------------------------------------------
    logic [2:0] ev_set;
    logic [2:0] ev_clr;

    assign ev_set = {match_b, match_a, ack_hit};
    assign ev_clr = (wsel_stat && s_axi_wstrb[0]) ? s_axi_wdata[2:0] : 3'h0;
    assign rd_hit = s_axi_araddr <= `IPIC_OFF_PEND && s_axi_araddr[1:0] == 2'h0;
    assign rd_data_w = (s_axi_araddr == `IPIC_OFF_SENSE) ? {24'h000000, sense_reg}
        : (s_axi_araddr == `IPIC_OFF_PRIO_A) ? {16'h0000, prio_a_reg}
        : (s_axi_araddr == `IPIC_OFF_PRIO_CF) ? {16'h0000, prio_cf_reg}
        : (s_axi_araddr == `IPIC_OFF_BSEL_A) ? {26'h0, bsel_a_reg}
        : (s_axi_araddr == `IPIC_OFF_BSEL_B) ? {26'h0, bsel_b_reg}
        : (s_axi_araddr == `IPIC_OFF_BCTRL) ? {28'h0000000, flags_reg}
        : (s_axi_araddr == `IPIC_OFF_STAT) ? {29'h0, status_reg}
        : (s_axi_araddr == `IPIC_OFF_MASK) ? {29'h0, mask_reg}
        : (s_axi_araddr == `IPIC_OFF_PEND) ? {22'h0, src_req}
        : 32'h00000000;

    // ---------------------------------------------
    // register bus handshake
    // ---------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= `IPIC_RESP_OKAY;
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
            rresp_reg <= `IPIC_RESP_OKAY;
            rd_sense_reg <= 1'b0;
        end else begin
            awready_reg <= s_axi_awvalid && s_axi_wvalid && !awready_reg && !bvalid_reg;
            wready_reg <= s_axi_awvalid && s_axi_wvalid && !awready_reg && !bvalid_reg;
            if (wr_fire) begin
                bvalid_reg <= 1'b1;
                bresp_reg <= wr_hit ? `IPIC_RESP_OKAY : `IPIC_RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
            arready_reg <= s_axi_arvalid && !arready_reg && !rvalid_reg;
            if (rd_fire) begin
                rvalid_reg <= 1'b1;
                rdata_reg <= rd_data_w;
                rresp_reg <= rd_hit ? `IPIC_RESP_OKAY : `IPIC_RESP_SLVERR;
                rd_sense_reg <= s_axi_araddr == `IPIC_OFF_SENSE;
            end else if (s_axi_rready) begin
                rvalid_reg <= 1'b0;
            end
        end
    end

    // ---------------------------------------------
    // configuration registers
    // ---------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sense_reg <= `IPIC_RST_SENSE;
            prio_a_reg <= `IPIC_RST_PRIO;
            prio_cf_reg <= `IPIC_RST_PRIO;
            bsel_a_reg <= `IPIC_RST_BSEL;
            bsel_b_reg <= `IPIC_RST_BSEL;
            mask_reg <= `IPIC_RST_EV;
        end else begin
            if (wsel_sense && s_axi_wstrb[0]) begin
                sense_reg <= s_axi_wdata[7:0];
            end
            if (wsel_prio_a) begin
                prio_a_reg <= (prio_a_reg & ~wmask16) | (s_axi_wdata[15:0] & wmask16);
            end
            if (wsel_prio_cf) begin
                prio_cf_reg <= (prio_cf_reg & ~wmask16) | (s_axi_wdata[15:0] & wmask16);
            end
            if (wsel_bsel_a && s_axi_wstrb[0]) begin
                bsel_a_reg <= s_axi_wdata[5:0];
            end
            if (wsel_bsel_b && s_axi_wstrb[0]) begin
                bsel_b_reg <= s_axi_wdata[5:0];
            end
            if (wsel_mask && s_axi_wstrb[0]) begin
                mask_reg <= s_axi_wdata[2:0];
            end
        end
    end

    // ---------------------------------------------
    // break state, events and core handshake
    // ---------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cond_a_reg <= 1'b0;
            cond_b_reg <= 1'b0;
            flags_reg <= `IPIC_RST_FLAGS;
            brk_pend_reg <= 1'b0;
            status_reg <= `IPIC_RST_EV;
            irq_out_reg <= 1'b0;
            int_req_reg <= 1'b0;
            int_vector_reg <= 8'h00;
            int_idx_reg <= 4'h0;
            int_level_reg <= 4'h0;
        end else begin
            cond_a_reg <= brk_cond_a;
            cond_b_reg <= brk_cond_b;
            flags_reg <= (flags_reg & flag_keep) | flag_set;
            brk_pend_reg <= brk_pend_next;
            status_reg <= (status_reg & ~ev_clr) | ev_set;
            irq_out_reg <= |(status_reg & mask_reg);
            // drop the request in the acceptance cycle so it is not taken twice
            int_req_reg <= best_hit && !ack_hit;
            int_vector_reg <= src_vec[best_idx];
            int_idx_reg <= best_idx;
            int_level_reg <= best_lvl[4] ? 4'hF : best_lvl[3:0];
        end
    end

    assign s_axi_awready = awready_reg;
    assign s_axi_wready = wready_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
    assign int_req = int_req_reg;
    assign int_vector = int_vector_reg;
    assign int_table_addr = {int_vector_reg, 2'b00};
    assign int_level = int_level_reg;
    assign irq_out = irq_out_reg;

    // ---------------------------------------------
    // checks
    // ---------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence brk_accept_s;
        src_acc[0] && !match_a && !match_b;
    endsequence

    sequence dual_match_s;
        match_a && match_b;
    endsequence

    above_mask_a: assert property (int_req_reg && int_vector_reg != `IPIC_VEC_NMI
        |-> int_level_reg > $past(cpu_mask_level))
        else $error("request forwarded at or below the mask level");
    brk_level_a: assert property (int_req_reg && int_vector_reg == `IPIC_VEC_BRK |-> int_level_reg == 4'hF)
        else $error("break request not at level 15");
    brk_hold_a: assert property (brk_pend_reg && !src_acc[0] |=> brk_pend_reg)
        else $error("break request dropped before acceptance");
    brk_clear_a: assert property (brk_accept_s |=> !brk_pend_reg ##1 !int_req_reg || int_vector_reg != `IPIC_VEC_BRK
        || brk_pend_reg)
        else $error("accepted break request still pending");
    brk_gate_a: assert property (!cfg_ok_a && !brk_cond_b |=> !$rose(brk_pend_reg)
        && !$rose(flags_reg[`IPIC_FLAG_LBUS_A]) && !$rose(flags_reg[`IPIC_FLAG_IBUS_A]))
        else $error("break match flagged with a zero selection group");
    flag_sticky_a: assert property (flags_reg[`IPIC_FLAG_LBUS_A] && !wsel_bctrl |=> flags_reg[`IPIC_FLAG_LBUS_A])
        else $error("match flag cleared without a software write");
    one_req_a: assert property ((dual_match_s and (bsel_a_reg[4] && bsel_b_reg[4]))
        |=> brk_pend_reg && flags_reg[`IPIC_FLAG_LBUS_A] && flags_reg[`IPIC_FLAG_LBUS_B])
        else $error("dual match did not flag both channels");
    sense_upper_a: assert property (rvalid_reg && rd_sense_reg |-> rdata_reg[31:8] == 24'h000000)
        else $error("sense register upper bits read nonzero");
    vec_map_a: assert property (int_req_reg && int_idx_reg >= 4'h2 && int_idx_reg <= 4'h5
        |-> int_vector_reg == `IPIC_VEC_PIN0 + {4'h0, int_idx_reg - 4'h2})
        else $error("external pin vector mismatch");
    irq_follow_a: assert property (##1 irq_out_reg == |($past(status_reg) & $past(mask_reg)))
        else $error("interrupt output does not track masked status");
endmodule : ipic_ctrl

// ---- verilog/ipic_cfg.svh ----
// offsets, field positions, vectors and reset values of the interrupt controller
`ifndef IPIC_CFG_SVH
`define IPIC_CFG_SVH

`define IPIC_OFF_SENSE 8'h00
`define IPIC_OFF_PRIO_A 8'h04
`define IPIC_OFF_PRIO_CF 8'h08
`define IPIC_OFF_BSEL_A 8'h0C
`define IPIC_OFF_BSEL_B 8'h10
`define IPIC_OFF_BCTRL 8'h14
`define IPIC_OFF_STAT 8'h18
`define IPIC_OFF_MASK 8'h1C
`define IPIC_OFF_PEND 8'h20

`define IPIC_SENSE_FW 2
`define IPIC_PRIO_FW 4
`define IPIC_FLAG_LBUS_A 0
`define IPIC_FLAG_IBUS_A 1
`define IPIC_FLAG_LBUS_B 2
`define IPIC_FLAG_IBUS_B 3

`define IPIC_EV_ACCEPT 0
`define IPIC_EV_MATCH_A 1
`define IPIC_EV_MATCH_B 2

`define IPIC_VEC_NMI 8'h0B
`define IPIC_VEC_BRK 8'h0C
`define IPIC_VEC_PIN0 8'h40
`define IPIC_VEC_PER0 8'h58
`define IPIC_VEC_PER_STEP 8'h04
`define IPIC_LVL_BRK 5'h0F
`define IPIC_LVL_NMI 5'h10

`define IPIC_RST_SENSE 8'h00
`define IPIC_RST_PRIO 16'h0000
`define IPIC_RST_BSEL 6'h00
`define IPIC_RST_FLAGS 4'h0
`define IPIC_RST_EV 3'h0

`define IPIC_RESP_OKAY 2'h0
`define IPIC_RESP_SLVERR 2'h2

`endif

// ---- verilog/ipic_pkg.sv ----
// types of the interrupt controller
package ipic_pkg;
    // sense field codes in order 00, 01, 10, 11
    typedef enum logic [1:0] {
        SENSE_LOW,
        SENSE_FALL,
        SENSE_RISE,
        SENSE_BOTH
    } ipic_sense_t;

    typedef logic [4:0] ipic_level_t;
    typedef logic [7:0] ipic_vector_t;
endpackage : ipic_pkg

// ---- verilog/ipic_pin_sense.sv ----
// synchroniser and request detector for one external interrupt pin
`timescale 1ns/1ps
module ipic_pin_sense (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // pin and mode
    input wire logic pin_async,
    input wire ipic_pkg::ipic_sense_t mode,
    // request handshake
    input wire logic accept,
    output logic pending
);
    import ipic_pkg::*;

    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    logic filt_reg;
    logic pend_reg;
    logic filt_next;
    logic fall_w;
    logic rise_w;
    logic edge_hit;
    logic pend_next;

    // ---------------------------------------------
    // filtered pin level
    // ---------------------------------------------
    assign filt_next = (s2_reg == s3_reg) ? s2_reg : filt_reg;
    assign fall_w = filt_reg && !filt_next;
    assign rise_w = !filt_reg && filt_next;
    assign edge_hit = (mode == SENSE_FALL && fall_w) || (mode == SENSE_RISE && rise_w)
        || (mode == SENSE_BOTH && (fall_w || rise_w));
    // level mode follows the pin, edge modes latch until accepted
    assign pend_next = (mode == SENSE_LOW) ? !filt_next : (edge_hit || (pend_reg && !accept));
    assign pending = pend_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1_reg <= 1'b1;
            s2_reg <= 1'b1;
            s3_reg <= 1'b1;
            filt_reg <= 1'b1;
            pend_reg <= 1'b0;
        end else begin
            s1_reg <= pin_async;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            filt_reg <= filt_next;
            pend_reg <= pend_next;
        end
    end

    // ---------------------------------------------
    // checks
    // ---------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    low_level_req_a: assert property ((mode == SENSE_LOW && $stable(mode)) |=> pend_reg == !$past(filt_next))
        else $error("level mode request does not follow the pin");
    edge_hold_a: assert property ((pend_reg && mode != SENSE_LOW && !accept && $stable(mode)) |=> pend_reg)
        else $error("latched edge request lost before acceptance");
endmodule : ipic_pin_sense

// ---- testbench/ipic_core_model.sv ----
// processor core model that accepts offered interrupts
`timescale 1ns/1ps
module ipic_core_model (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // controller side
    input wire logic int_req,
    input wire logic [3:0] int_level,
    output logic cpu_ack,
    output logic [3:0] cpu_mask_level,
    // bench control
    input wire logic [1:0] ack_delay,
    input wire logic mask_set,
    input wire logic [3:0] mask_val
);
    // ----------------------------------------
    // acceptance after a chosen delay
    // ----------------------------------------
    logic [1:0] wait_reg;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cpu_ack <= 1'b0;
            cpu_mask_level <= 4'h0;
            wait_reg <= 2'h0;
        end else begin
            cpu_ack <= 1'b0;
            if (mask_set) begin
                cpu_mask_level <= mask_val;
            end else if (cpu_ack && int_req) begin
                // mask follows only an acceptance the controller takes
                cpu_mask_level <= int_level;
            end
            if (!mask_set && int_req && !cpu_ack && wait_reg == ack_delay) begin
                cpu_ack <= 1'b1;
                wait_reg <= 2'h0;
            end else if (!mask_set && int_req && !cpu_ack) begin
                wait_reg <= wait_reg + 2'h1;
            end
        end
    end
endmodule : ipic_core_model

// ---- testbench/test_irq_priority_interrupt_ctrl.sv ----
// testbench of the interrupt controller
`timescale 1ns/1ps
module test_irq_priority_interrupt_ctrl;
    logic aclk = 0, aresetn = 0;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 0, ext_int_pin = 4'hF, periph_req = 0, cpu_mask_level, int_level, mask_val = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, ack_delay = 0;
    logic nmi_pin = 1, brk_cond_a = 0, brk_cond_b = 0, cpu_ack, int_req, irq_out, mask_set = 0;
    logic [7:0] int_vector, acc_vec;
    logic [9:0] int_table_addr, acc_addr;
    logic [3:0] acc_lvl;
    int err_count = 0, total_checks = 0, acc_cnt = 0, cycles = 0;
    ipic_ctrl dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .ext_int_pin(ext_int_pin), .nmi_pin(nmi_pin), .periph_req(periph_req), .brk_cond_a(brk_cond_a),
        .brk_cond_b(brk_cond_b), .cpu_mask_level(cpu_mask_level), .cpu_ack(cpu_ack), .int_req(int_req),
        .int_vector(int_vector), .int_table_addr(int_table_addr), .int_level(int_level), .irq_out(irq_out));
    ipic_core_model core (.aclk(aclk), .aresetn(aresetn), .int_req(int_req), .int_level(int_level),
        .cpu_ack(cpu_ack), .cpu_mask_level(cpu_mask_level), .ack_delay(ack_delay), .mask_set(mask_set),
        .mask_val(mask_val));
    initial begin
        forever #50 aclk = ~aclk;
    end
    // ----------------------------------------
    // checks and bus tasks
    // ----------------------------------------
    task automatic tally_and_finish();
        if (err_count == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : tally_and_finish
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            err_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw_done, w_done;
        aw_done = 0;
        w_done = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hF;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1) begin
                aw_done = 1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wready === 1'b1) begin
                w_done = 1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        chk("bresp", 32'(er), 32'(s_axi_bresp));
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        chk("rdata", e, s_axi_rdata);
        chk("rresp", 32'(er), 32'(s_axi_rresp));
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask : rd
    task automatic set_mask(input logic [3:0] m);
        mask_set <= 1'b1;
        mask_val <= m;
        @(posedge aclk);
        mask_set <= 1'b0;
        @(posedge aclk);
    endtask : set_mask
    task automatic acc_chk(input int n0, input logic [7:0] v, input logic [3:0] l);
        while (acc_cnt == n0) @(posedge aclk);
        chk("int_vector", 32'(v), 32'(acc_vec));
        chk("int_table_addr", {22'h0, v, 2'b00}, 32'(acc_addr));
        chk("int_level", 32'(l), 32'(acc_lvl));
        repeat (2) @(posedge aclk);
        chk("cpu_mask_level", 32'(l), 32'(cpu_mask_level));
        set_mask(4'h0);
    endtask : acc_chk
    always @(posedge aclk) begin
        cycles++;
        if (cpu_ack === 1'b1 && int_req === 1'b1) begin
            acc_cnt++;
            acc_vec = int_vector;
            acc_addr = int_table_addr;
            acc_lvl = int_level;
            if (int_vector >= 8'h58) periph_req[2'((int_vector - 8'h58) >> 2)] <= 1'b0;
        end
        if (cycles == 6000) begin
            err_count++;
            tally_and_finish();
        end
    end
    initial begin
        int n;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(8'h00, 32'h0, 2'h0);
        wr(8'h00, 32'h000000FF, 2'h0);
        rd(8'h00, 32'h000000FF, 2'h0);
        wr(8'h40, 32'h0, 2'h2);
        rd(8'h40, 32'h0, 2'h2);
        wr(8'h00, 32'h000000E4, 2'h0);
        wr(8'h04, 32'h00001234, 2'h0);
        for (int g = 0; g < 4; g++) begin
            n = acc_cnt;
            ext_int_pin[g] <= 1'b0;
            repeat (10) @(posedge aclk);
            ext_int_pin[g] <= 1'b1;
            acc_chk(n, 8'h40 + 8'(g), 4'(g + 1));
        end
        acc_chk(n + 1, 8'h43, 4'h4);
        wr(8'h0C, 32'h3F, 2'h0);
        wr(8'h10, 32'h3F, 2'h0);
        set_mask(4'hF);
        n = acc_cnt;
        brk_cond_a <= 1'b1;
        brk_cond_b <= 1'b1;
        @(posedge aclk);
        brk_cond_a <= 1'b0;
        brk_cond_b <= 1'b0;
        repeat (6) @(posedge aclk);
        chk("int_req", 32'h0, 32'(int_req));
        ack_delay <= 2'h3;
        set_mask(4'h0);
        acc_chk(n, 8'h0C, 4'hF);
        ack_delay <= 2'h0;
        repeat (6) @(posedge aclk);
        chk("accept_count", 32'(n + 1), 32'(acc_cnt));
        rd(8'h14, 32'hF, 2'h0);
        rd(8'h18, 32'h7, 2'h0);
        wr(8'h1C, 32'h2, 2'h0);
        repeat (2) @(posedge aclk);
        chk("irq_out", 32'h1, 32'(irq_out));
        wr(8'h18, 32'h2, 2'h0);
        repeat (2) @(posedge aclk);
        chk("irq_out", 32'h0, 32'(irq_out));
        rd(8'h18, 32'h5, 2'h0);
        wr(8'h14, 32'h0, 2'h0);
        rd(8'h14, 32'h0, 2'h0);
        wr(8'h0C, 32'h0F, 2'h0);
        n = acc_cnt;
        brk_cond_a <= 1'b1;
        @(posedge aclk);
        brk_cond_a <= 1'b0;
        repeat (8) @(posedge aclk);
        chk("accept_count", 32'(n), 32'(acc_cnt));
        rd(8'h14, 32'h0, 2'h0);
        wr(8'h08, 32'h7700, 2'h0);
        n = acc_cnt;
        periph_req <= 4'h3;
        acc_chk(n, 8'h58, 4'h7);
        acc_chk(n + 1, 8'h5C, 4'h7);
        n = acc_cnt;
        nmi_pin <= 1'b0;
        repeat (10) @(posedge aclk);
        nmi_pin <= 1'b1;
        acc_chk(n, 8'h0B, 4'hF);
        tally_and_finish();
    end
endmodule : test_irq_priority_interrupt_ctrl
